// >>> core/rds_pkg.sv
package rds_pkg;
  // ==========================================================================
  // Clock and time base.
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned SEC_CYC = CLK_HZ;
  localparam logic [25:0] SEC_LAST = 26'(SEC_CYC - 1);
  localparam int unsigned WARMUP_S = 120;
  localparam int unsigned LOCK_RB_S = 20 * 60;
  localparam int unsigned LOCK_OC_S = 5 * 60;
  localparam int unsigned FINE_RB_S = 4 * 3600;
  localparam int unsigned FINE_OC_S = 5;
  localparam int unsigned HOLD_DEF_S = 24 * 3600;
  localparam int unsigned PPS_MIN_S = 3;
  localparam logic [31:0] HOLD_RST = 32'(HOLD_DEF_S);

  // ==========================================================================
  // Avalon register map, byte addresses.
  localparam logic [4:0] A_CTRL = 5'h00;
  localparam logic [4:0] A_HOLD_DUR = 5'h04;
  localparam logic [4:0] A_DELAY = 5'h08;
  localparam logic [4:0] A_STATUS = 5'h0c;
  localparam logic [4:0] A_ELAPSED = 5'h10;
  localparam logic [4:0] A_EFF_DLY = 5'h14;
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_FORCE = 4;
  localparam int CTRL_OSC_LSB = 8;
  localparam int ST_LOCK_LSB = 0;
  localparam int ST_TOD_LSB = 4;
  localparam int ST_PPS_LSB = 8;
  localparam int ST_READY_PART = 12;
  localparam int ST_READY_FULL = 13;
  localparam int ST_UNRELIABLE = 14;

  // ==========================================================================
  // Enumerations.
  typedef enum logic [2:0] {
    RDS_SRC_INTERNAL = 3'b000,
    RDS_SRC_CLOCK = 3'b001,
    RDS_SRC_TOD = 3'b010,
    RDS_SRC_PPS_PORT = 3'b011,
    RDS_SRC_PPS_COAX = 3'b100,
    RDS_SRC_ETH_A = 3'b101,
    RDS_SRC_ETH_B = 3'b110,
    RDS_SRC_GNSS = 3'b111
  } rds_src_e;

  typedef enum logic [1:0] {
    RDS_OSC_TCXO = 2'b00,
    RDS_OSC_OCXO = 2'b01,
    RDS_OSC_RB = 2'b10
  } rds_osc_e;

  typedef enum logic [2:0] {
    RDS_ST_WARMUP = 3'b000,
    RDS_ST_LOCKING = 3'b001,
    RDS_ST_FINE = 3'b010,
    RDS_ST_LOCKED = 3'b011,
    RDS_ST_HOLD = 3'b100,
    RDS_ST_HOLD_TO = 3'b101,
    RDS_ST_FREE = 3'b110,
    RDS_ST_REF_ERR = 3'b111
  } rds_state_e;

  typedef enum logic [1:0] {
    RDS_TOD_NONE = 2'b00,
    RDS_TOD_G8271 = 2'b01,
    RDS_TOD_NMEA = 2'b10,
    RDS_TOD_CT = 2'b11
  } rds_tod_e;

  typedef enum logic [1:0] {
    RDS_PPS_NONE = 2'b00,
    RDS_PPS_1S = 2'b01,
    RDS_PPS_2S = 2'b10
  } rds_pps_e;

  typedef struct packed {
    logic warmup_done;
    logic ref_present;
    logic ref_fault;
    logic converged;
  } rds_ref_s;
endpackage : rds_pkg

// >>> core/rds_sync3.sv
`timescale 1ns/10ps
module rds_sync3 import rds_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic async_in,
  output logic sync_out
);
  logic [2:0] sh_q;

  // The change is taken once the second and third stages agree.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      sh_q <= 3'h0;
      sync_out <= 1'b0;
    end
    else if (clk_en)
    begin
      sh_q <= {sh_q[1:0], async_in};
      if (sh_q[2] == sh_q[1])
      begin
        sync_out <= sh_q[2];
      end
    end
  end
endmodule : rds_sync3

// >>> core/rds_pps_class.sv
`timescale 1ns/10ps
module rds_pps_class import rds_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic sec_tick,
  input wire logic pulse,
  output rds_pps_e pps_type
);
  logic pulse_q;
  logic [1:0] gap_q;
  logic [1:0] good_q;
  logic rise;
  logic [2:0] gap_now;

  assign rise = pulse & ~pulse_q;
  // A second tick in the cycle of the edge still counts toward this gap.
  assign gap_now = {1'b0, gap_q} + {2'h0, sec_tick};

  // ==========================================================================
  // pulse classification
  // Seconds between rising edges decide 1 or 2 s; four seconds without an edge means no pulse.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pulse_q <= 1'b0;
      gap_q <= 2'h0;
      good_q <= 2'h0;
      pps_type <= RDS_PPS_NONE;
    end
    else if (clk_en)
    begin
      pulse_q <= pulse;
      if (rise)
      begin
        gap_q <= 2'h0;
        if (gap_now == 3'h1 || gap_now == 3'h2)
        begin
          if (good_q != 2'h3)
          begin
            good_q <= good_q + 2'h1;
          end
          else
          begin
            pps_type <= (gap_now == 3'h1) ? RDS_PPS_1S : RDS_PPS_2S;
          end
        end
        else
        begin
          good_q <= 2'h0;
        end
      end
      else if (sec_tick)
      begin
        if (gap_q == 2'h3)
        begin
          good_q <= 2'h0;
          pps_type <= RDS_PPS_NONE;
        end
        else
        begin
          gap_q <= gap_q + 2'h1;
        end
      end
    end
  end
endmodule : rds_pps_class

// >>> core/rds_core.sv
// Behaviour
// - Warm-up reported after start; no accuracy claimed during warm-up.
// - Locking follows warm-up; twenty minutes rubidium, five minutes oven.
// - Fine locking follows; four hours rubidium, few seconds oven.
// - Fine locking signals partial readiness; only locked signals full readiness.
// - Locked entered when difference stops shrinking; keeps tracking.
// - Holdover only after lock to time or phase reference lost.
// - Force-holdover puts oven or rubidium units into holdover.
// - Temperature-compensated oscillator refuses forced and automatic holdover.
// - Holdover elapsed count starts at zero each holdover period.
// - Elapsed above programmed duration gives holdover timeout, unreliable.
// - Holdover duration is programmable, resets to twenty-four hours.
// - Free running when undisciplined; phase and time marked unreliable.
// - Reference error when locking sequence cannot complete.
// - Input selector offers eight reference sources.
// - Delay compensation applies only to pulse or time-of-day sources.
// - One delay setting serves phase and time references, not frequency.
// - Time-of-day protocol reported as none, G.8271, NMEA or CT.
// - Pulse train classed as one or two seconds, or none.
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module rds_core import rds_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SEC_CYC,
  parameter int unsigned WARMUP_SEC = WARMUP_S,
  parameter int unsigned LOCK_RB_SEC = LOCK_RB_S,
  parameter int unsigned LOCK_OC_SEC = LOCK_OC_S,
  parameter int unsigned FINE_RB_SEC = FINE_RB_S,
  parameter int unsigned FINE_OC_SEC = FINE_OC_S
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire rds_ref_s ref_info,
  input wire logic pps_pin,
  input wire logic [1:0] tod_proto,
  output rds_state_e lock_state,
  output logic ready_partial,
  output logic ready_full,
  output logic unreliable,
  output logic [31:0] eff_delay
);
  logic [2:0] sel_q;
  logic force_q;
  logic [1:0] osc_q;
  logic [31:0] hold_dur_q;
  logic [31:0] delay_q;
  logic [31:0] elapsed_q;
  logic [31:0] sec_in_state_q;
  logic [25:0] div_q;
  logic sec_tick;
  logic pps_sync;
  logic acc_q;
  rds_pps_e pps_type;
  rds_tod_e tod_q;
  rds_state_e state_d;
  logic ref_timed;
  logic hold_ok;
  logic was_locked_q;
  logic pulse_src;
  logic [31:0] lock_lim;
  logic [31:0] fine_lim;
  rds_ref_s ref_q;

  assign pulse_src = (sel_q == RDS_SRC_PPS_PORT) || (sel_q == RDS_SRC_PPS_COAX)
    || (sel_q == RDS_SRC_TOD);
  assign ref_timed = pulse_src || (sel_q == RDS_SRC_GNSS);
  assign hold_ok = (osc_q != RDS_OSC_TCXO);
  assign lock_lim = (osc_q == RDS_OSC_RB) ? 32'(LOCK_RB_SEC) : 32'(LOCK_OC_SEC);
  assign fine_lim = (osc_q == RDS_OSC_RB) ? 32'(FINE_RB_SEC) : 32'(FINE_OC_SEC);
  assign sec_tick = clk_en && (div_q == 26'(SEC_CYCLES - 1));

  // ==========================================================================
  // Pin synchroniser and pulse classifier.
  rds_sync3 u_pps_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .async_in(pps_pin),
    .sync_out(pps_sync)
  );

  rds_pps_class u_pps (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .sec_tick(sec_tick),
    .pulse(pps_sync),
    .pps_type(pps_type)
  );

  // ==========================================================================
  // Seconds divider.
  // one second base
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      div_q <= 26'h0;
    end
    else if (clk_en)
    begin
      div_q <= sec_tick ? 26'h0 : div_q + 26'h1;
    end
  end

  // ==========================================================================
  // Avalon slave: one wait cycle, then the answer.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      acc_q <= 1'b0;
      avs_waitrequest <= 1'b1;
    end
    else if (clk_en)
    begin
      acc_q <= (avs_read || avs_write) && !acc_q;
      avs_waitrequest <= !((avs_read || avs_write) && !acc_q);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      sel_q <= RDS_SRC_INTERNAL;
      force_q <= 1'b0;
      osc_q <= RDS_OSC_TCXO;
      hold_dur_q <= HOLD_RST;
      delay_q <= 32'h0;
    end
    else if (clk_en && acc_q && avs_write)
    begin
      case (avs_address)
        A_CTRL:
        begin
          if (avs_byteenable[0])
          begin
            sel_q <= avs_writedata[CTRL_SEL_LSB +: 3];
            force_q <= avs_writedata[CTRL_FORCE];
          end
          if (avs_byteenable[1])
          begin
            osc_q <= avs_writedata[CTRL_OSC_LSB +: 2];
          end
        end
        A_HOLD_DUR:
        begin
          for (int b = 0; b < 4; b++)
          begin
            if (avs_byteenable[b])
            begin
              hold_dur_q[8*b +: 8] <= avs_writedata[8*b +: 8];
            end
          end
        end
        A_DELAY:
        begin
          for (int b = 0; b < 4; b++)
          begin
            if (avs_byteenable[b])
            begin
              delay_q[8*b +: 8] <= avs_writedata[8*b +: 8];
            end
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      avs_readdata <= 32'h0;
    end
    else if (clk_en)
    begin
      avs_readdata <= 32'h0;
      if (avs_read && !acc_q)
      begin
        case (avs_address)
          A_CTRL: avs_readdata <= {22'h0, osc_q, 3'h0, force_q, 1'b0, sel_q};
          A_HOLD_DUR: avs_readdata <= hold_dur_q;
          A_DELAY: avs_readdata <= delay_q;
          A_STATUS: avs_readdata <= {17'h0, unreliable, ready_full, ready_partial,
            2'h0, pps_type, 2'h0, tod_q, 1'b0, lock_state};
          A_ELAPSED: avs_readdata <= elapsed_q;
          A_EFF_DLY: avs_readdata <= eff_delay;
          default: avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  // ==========================================================================
  // Reference inputs and protocol report.
  // tod protocol report
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      tod_q <= RDS_TOD_NONE;
      ref_q <= '0;
    end
    else if (clk_en)
    begin
      ref_q <= ref_info;
      tod_q <= (sel_q == RDS_SRC_TOD) ? rds_tod_e'(tod_proto) : RDS_TOD_NONE;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      eff_delay <= 32'h0;
    end
    else if (clk_en)
    begin
      eff_delay <= pulse_src ? delay_q : 32'h0;
    end
  end

  // ==========================================================================
  // Discipline state machine.
  always_comb
  begin
    state_d = lock_state;
    case (lock_state)
      RDS_ST_WARMUP:
        if (ref_q.warmup_done && sec_in_state_q >= 32'(WARMUP_SEC))
          state_d = (sel_q == RDS_SRC_INTERNAL) ? RDS_ST_FREE : RDS_ST_LOCKING;
      RDS_ST_LOCKING:
        if (ref_q.ref_fault)
          state_d = RDS_ST_REF_ERR;
        else if (!ref_q.ref_present)
          state_d = (hold_ok && was_locked_q) ? RDS_ST_HOLD : RDS_ST_FREE;
        else if (sec_in_state_q >= lock_lim)
          state_d = RDS_ST_FINE;
      RDS_ST_FINE:
        if (ref_q.ref_fault)
          state_d = RDS_ST_REF_ERR;
        else if (!ref_q.ref_present)
          state_d = (hold_ok && was_locked_q) ? RDS_ST_HOLD : RDS_ST_FREE;
        else if (sec_in_state_q >= fine_lim && ref_q.converged)
          state_d = RDS_ST_LOCKED;
      RDS_ST_LOCKED:
        if (!ref_q.ref_present)
          state_d = (hold_ok && ref_timed) ? RDS_ST_HOLD : RDS_ST_FREE;
        else if (force_q && hold_ok && ref_timed)
          state_d = RDS_ST_HOLD;
      RDS_ST_HOLD:
        if (elapsed_q > hold_dur_q)
          state_d = RDS_ST_HOLD_TO;
        else if (!force_q && ref_q.ref_present)
          state_d = RDS_ST_LOCKING;
      RDS_ST_HOLD_TO:
        if (!force_q && ref_q.ref_present)
          state_d = RDS_ST_LOCKING;
      RDS_ST_FREE:
        if (sel_q != RDS_SRC_INTERNAL && ref_q.ref_present && !force_q)
          state_d = RDS_ST_LOCKING;
      RDS_ST_REF_ERR:
        if (!ref_q.ref_fault && ref_q.ref_present)
          state_d = RDS_ST_LOCKING;
      default:
        state_d = RDS_ST_WARMUP;
    endcase
    if (force_q && hold_ok && was_locked_q &&
        (lock_state == RDS_ST_LOCKING || lock_state == RDS_ST_FINE))
      state_d = RDS_ST_HOLD;
    if (lock_state != RDS_ST_WARMUP && lock_state != RDS_ST_HOLD &&
        lock_state != RDS_ST_HOLD_TO && sel_q == RDS_SRC_INTERNAL && !force_q)
      state_d = RDS_ST_FREE;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      lock_state <= RDS_ST_WARMUP;
      sec_in_state_q <= 32'h0;
      was_locked_q <= 1'b0;
    end
    else if (clk_en)
    begin
      lock_state <= state_d;
      if (state_d != lock_state)
        sec_in_state_q <= 32'h0;
      else if (sec_tick && sec_in_state_q != 32'hffffffff)
        sec_in_state_q <= sec_in_state_q + 32'h1;
      if (lock_state == RDS_ST_LOCKED)
        was_locked_q <= ref_timed;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      elapsed_q <= 32'h0;
    end
    else if (clk_en)
    begin
      if (lock_state != RDS_ST_HOLD && lock_state != RDS_ST_HOLD_TO)
        elapsed_q <= 32'h0;
      else if (sec_tick && elapsed_q != 32'hffffffff)
        elapsed_q <= elapsed_q + 32'h1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ready_partial <= 1'b0;
      ready_full <= 1'b0;
      unreliable <= 1'b1;
    end
    else if (clk_en)
    begin
      ready_partial <= (state_d == RDS_ST_FINE) || (state_d == RDS_ST_LOCKED) ||
        (state_d == RDS_ST_HOLD);
      ready_full <= (state_d == RDS_ST_LOCKED);
      unreliable <= (state_d == RDS_ST_WARMUP) || (state_d == RDS_ST_HOLD_TO) ||
        (state_d == RDS_ST_FREE) || (state_d == RDS_ST_REF_ERR) ||
        (state_d == RDS_ST_LOCKING);
    end
  end

  // ==========================================================================
  // Checks.
  a_hold_needs_osc: assert property (@(posedge ref_clk) disable iff (reset)
    (lock_state == RDS_ST_HOLD) |-> (osc_q != RDS_OSC_TCXO))
    else $error("holdover with tcxo");
  a_full_only_locked: assert property (@(posedge ref_clk) disable iff (reset)
    ready_full |-> (lock_state == RDS_ST_LOCKED))
    else $error("full ready outside locked");
  a_timeout_move: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && lock_state == RDS_ST_HOLD && elapsed_q > hold_dur_q) |=>
    (lock_state == RDS_ST_HOLD_TO) ##1 (unreliable || !clk_en))
    else $error("holdover timeout missed");
  a_elapsed_zero: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && lock_state != RDS_ST_HOLD && lock_state != RDS_ST_HOLD_TO) |=>
    (elapsed_q == 32'h0))
    else $error("elapsed not cleared");
  a_delay_gate: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && !pulse_src) |=> (eff_delay == 32'h0))
    else $error("delay on frequency source");
  a_free_unrel: assert property (@(posedge ref_clk) disable iff (reset)
    (lock_state == RDS_ST_FREE) |-> unreliable)
    else $error("free run not unreliable");
  a_warm_no_ready: assert property (@(posedge ref_clk) disable iff (reset)
    (lock_state == RDS_ST_WARMUP) |-> !ready_full)
    else $error("ready in warm-up");
  a_elapsed_sat: assert property (@(posedge ref_clk) disable iff (reset)
    (elapsed_q == 32'hffffffff) |=> (elapsed_q != 32'h0 || lock_state != $past(lock_state)
    || (lock_state != RDS_ST_HOLD && lock_state != RDS_ST_HOLD_TO)))
    else $error("elapsed wrapped");
endmodule : rds_core

// >>> bench/rds_ref_model.sv
`timescale 1ns/10ps
// ============================================================
// External reference source: lock hints, pulse train and ToD code.
module rds_ref_model import rds_pkg::*;
(
  input wire logic ref_clk,
  input wire logic warm,
  input wire logic present,
  input wire logic fault,
  input wire logic conv,
  input wire logic [7:0] period,
  input wire logic [1:0] tod,
  output rds_ref_s ref_info,
  output logic pps_pin,
  output logic [1:0] tod_proto
);
  logic [7:0] cnt_q = 8'h00;
  // The ToD code is only seen while the source is connected.
  always_ff @(posedge ref_clk)
  begin
    ref_info <= '{warmup_done: warm, ref_present: present, ref_fault: fault, converged: conv};
    tod_proto <= present ? tod : 2'h0;
  end
  // A period of zero leaves the pulse pin low, as an unplugged cable does.
  always_ff @(posedge ref_clk)
  begin
    if (period == 8'h00 || cnt_q >= period - 8'h01)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_q + 8'h01;
    pps_pin <= (period != 8'h00) && (cnt_q < 8'h02);
  end
endmodule : rds_ref_model

// >>> bench/test_reference_discipline_status.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module test_reference_discipline_status import rds_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic [3:0] avs_byteenable = 4'hf;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  rds_ref_s ref_info;
  logic pps_pin;
  logic [1:0] tod_proto;
  rds_state_e lock_state;
  logic ready_partial;
  logic ready_full;
  logic unreliable;
  logic [31:0] eff_delay;
  logic warm = 1'b0;
  logic present = 1'b0;
  logic fault = 1'b0;
  logic conv = 1'b0;
  logic [7:0] period = 8'h00;
  logic [1:0] tod = 2'h0;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] d;

  rds_ref_model partner (.ref_clk(ref_clk), .warm(warm), .present(present), .fault(fault),
    .conv(conv), .period(period), .tod(tod), .ref_info(ref_info), .pps_pin(pps_pin),
    .tod_proto(tod_proto));

  rds_core #(.SEC_CYCLES(10), .WARMUP_SEC(2), .LOCK_OC_SEC(3),
    .FINE_OC_SEC(2)) dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ref_info(ref_info), .pps_pin(pps_pin),
    .tod_proto(tod_proto), .lock_state(lock_state), .ready_partial(ready_partial),
    .ready_full(ready_full), .unreliable(unreliable), .eff_delay(eff_delay));

  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ============================================================
  // Bus and sequencing tasks.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  // One access; the request stands until waitrequest is sampled low.
  task automatic av_acc(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 40);
    `CHK("waitrequest", 1'b0, avs_waitrequest)
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av_acc

  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    logic [31:0] x;
    av_acc(1'b1, a, v, x);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    av_acc(1'b0, a, 32'h0, v);
  endtask : rd

  task automatic wait_st(input rds_state_e s, input int lim);
    int n;
    n = 0;
    while (lock_state !== s && n < lim)
    begin
      @(posedge ref_clk);
      n++;
    end
    `CHK("lock_state", s, lock_state)
  endtask : wait_st

  task automatic wait_fld(input int lsb, input logic [1:0] v);
    logic [31:0] x;
    int n;
    n = 0;
    do
    begin
      rd(A_STATUS, x);
      n++;
    end
    while (x[lsb +: 2] !== v && n < 60);
    `CHK("status_field", v, x[lsb +: 2])
  endtask : wait_fld

  function automatic logic [31:0] ctrl_v(rds_osc_e o, logic f, rds_src_e s);
    return {22'h0, o, 3'h0, f, 1'b0, s};
  endfunction : ctrl_v

  task automatic do_reset();
    reset <= 1'b1;
    warm <= 1'b0;
    present <= 1'b0;
    fault <= 1'b0;
    conv <= 1'b0;
    period <= 8'h00;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
  endtask : do_reset

  initial
  begin
    forever
    begin
      @(posedge ref_clk);
      cyc++;
      if (cyc == 20000)
      begin
        miscompares++;
        finish_test();
      end
    end
  end

  // ============================================================
  // Test sequence.
  initial
  begin
    do_reset();
    `CHK("state", RDS_ST_WARMUP, lock_state)
    `CHK("partial", 1'b0, ready_partial)
    `CHK("full", 1'b0, ready_full)
    rd(A_HOLD_DUR, d);
    `CHK("hold_dur", 32'h0001_5180, d)
    rd(5'h18, d);
    `CHK("unmapped", 32'h0, d)
    wr(A_STATUS, 32'hffff_ffff);
    rd(A_STATUS, d);
    `CHK("status_ro", RDS_ST_WARMUP, d[2:0])
    avs_byteenable <= 4'h1;
    wr(A_HOLD_DUR, 32'hffff_ffaa);
    avs_byteenable <= 4'hf;
    rd(A_HOLD_DUR, d);
    `CHK("hold_dur_lane", 32'h0001_51aa, d)
    $display("test reset_map done");
    wr(A_DELAY, 32'h0000_0123);
    for (int s = 0; s < 8; s++)
    begin
      wr(A_CTRL, ctrl_v(RDS_OSC_OCXO, 1'b0, rds_src_e'(s)));
      repeat (2) @(posedge ref_clk);
      rd(A_EFF_DLY, d);
      `CHK("eff_reg", (s == 2 || s == 3 || s == 4) ? 32'h123 : 32'h0, d)
      `CHK("eff_port", (s == 2 || s == 3 || s == 4) ? 32'h123 : 32'h0, eff_delay)
    end
    $display("test delay_sources done");
    wr(A_CTRL, ctrl_v(RDS_OSC_OCXO, 1'b0, RDS_SRC_TOD));
    present <= 1'b1;
    for (int t = 0; t < 4; t++)
    begin
      tod <= 2'(t);
      repeat (4) @(posedge ref_clk);
      wait_fld(ST_TOD_LSB, 2'(t));
    end
    period <= 8'd10;
    wait_fld(ST_PPS_LSB, RDS_PPS_1S);
    period <= 8'd20;
    wait_fld(ST_PPS_LSB, RDS_PPS_2S);
    period <= 8'd0;
    wait_fld(ST_PPS_LSB, RDS_PPS_NONE);
    $display("test detect done");
    wr(A_CTRL, ctrl_v(RDS_OSC_OCXO, 1'b0, RDS_SRC_PPS_PORT));
    period <= 8'd10;
    warm <= 1'b1;
    wait_st(RDS_ST_LOCKING, 300);
    `CHK("partial", 1'b0, ready_partial)
    wait_st(RDS_ST_FINE, 300);
    `CHK("partial", 1'b1, ready_partial)
    `CHK("full", 1'b0, ready_full)
    conv <= 1'b1;
    wait_st(RDS_ST_LOCKED, 300);
    `CHK("full", 1'b1, ready_full)
    $display("test lock_walk done");
    wr(A_HOLD_DUR, 32'h3);
    wr(A_CTRL, ctrl_v(RDS_OSC_OCXO, 1'b1, RDS_SRC_PPS_PORT));
    wait_st(RDS_ST_HOLD, 20);
    rd(A_ELAPSED, d);
    `CHK("elapsed_start", 1'b1, d <= 32'h1)
    clk_en <= 1'b0;
    present <= 1'b0;
    period <= 8'd0;
    repeat (60) @(posedge ref_clk);
    `CHK("frozen", RDS_ST_HOLD, lock_state)
    clk_en <= 1'b1;
    repeat (20) @(posedge ref_clk);
    `CHK("still_hold", RDS_ST_HOLD, lock_state)
    wait_st(RDS_ST_HOLD_TO, 40);
    rd(A_ELAPSED, d);
    `CHK("elapsed_over", 1'b1, d > 32'h3)
    `CHK("unreliable", 1'b1, unreliable)
    $display("test holdover done");
    do_reset();
    wr(A_CTRL, ctrl_v(RDS_OSC_TCXO, 1'b0, RDS_SRC_PPS_PORT));
    warm <= 1'b1;
    present <= 1'b1;
    conv <= 1'b1;
    period <= 8'd10;
    wait_st(RDS_ST_LOCKED, 400);
    wr(A_CTRL, ctrl_v(RDS_OSC_TCXO, 1'b1, RDS_SRC_PPS_PORT));
    repeat (10) @(posedge ref_clk);
    `CHK("no_force", RDS_ST_LOCKED, lock_state)
    present <= 1'b0;
    wait_st(RDS_ST_FREE, 40);
    `CHK("unreliable", 1'b1, unreliable)
    $display("test tcxo done");
    do_reset();
    wr(A_CTRL, ctrl_v(RDS_OSC_OCXO, 1'b0, RDS_SRC_PPS_PORT));
    warm <= 1'b1;
    present <= 1'b1;
    wait_st(RDS_ST_LOCKING, 300);
    present <= 1'b0;
    wait_st(RDS_ST_FREE, 40);
    do_reset();
    wr(A_CTRL, ctrl_v(RDS_OSC_OCXO, 1'b0, RDS_SRC_PPS_PORT));
    warm <= 1'b1;
    present <= 1'b1;
    fault <= 1'b1;
    wait_st(RDS_ST_REF_ERR, 300);
    do_reset();
    wr(A_CTRL, ctrl_v(RDS_OSC_OCXO, 1'b0, RDS_SRC_INTERNAL));
    warm <= 1'b1;
    present <= 1'b1;
    wait_st(RDS_ST_FREE, 300);
    $display("test faults done");
    finish_test();
  end
endmodule : test_reference_discipline_status
